/* core/bmrc_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef BMRC_REGS_SVH
`define BMRC_REGS_SVH

// ==========================================================
// Timing
`define BMRC_CLK_HZ 64'd10000000
`define BMRC_RST_MS 64'd500
`define BMRC_DEB_US 64'd10000
`define BMRC_NMI_US 64'd10
// Reset must be strictly longer than the printed time, so one cycle is added
`define BMRC_RST_CYC (((`BMRC_RST_MS * `BMRC_CLK_HZ) / 64'd1000) + 64'd1)
`define BMRC_DEB_CYC (((`BMRC_DEB_US * `BMRC_CLK_HZ) + 64'd999999) / 64'd1000000)
`define BMRC_NMI_CYC (((`BMRC_NMI_US * `BMRC_CLK_HZ) + 64'd999999) / 64'd1000000)

// ==========================================================
// Fixed boot mode number
`define BMRC_BOOT_MODE 4'h3

// ==========================================================
// Register byte offsets
`define BMRC_OFS_CTRL 4'h0
`define BMRC_OFS_STAT 4'h4
`define BMRC_OFS_NMIC 4'h8
`define BMRC_OFS_TMR 4'hC

// ==========================================================
// Control fields and reset value
`define BMRC_CTRL_BOOT 0
`define BMRC_CTRL_RST 1
`define BMRC_CTRL_NMIEN 2
`define BMRC_NMIEN_RST 1'h1

// ==========================================================
// Debounced input lanes
`define BMRC_IN_RST 0
`define BMRC_IN_BOOT 1
`define BMRC_IN_NMI 2
`define BMRC_IN_CTS 3

`endif

/* core/bmrc_pkg.sv */
// Types shared by the boot mode reset controller
package bmrc_pkg;

	// ==========================================================
	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		BMRC_ST_USR_RST = 4'h1,
		BMRC_ST_USR_RUN = 4'h2,
		BMRC_ST_BOOT_RST = 4'h4,
		BMRC_ST_BOOT_RUN = 4'h8
	} bmrc_state_t;

	typedef logic [3:0] bmrc_lanes_t;

endpackage : bmrc_pkg

/* core/bmrc_if.sv */
// Raw and conditioned control inputs between top and input conditioner
interface bmrc_if;
	logic [3:0] raw;
	logic [3:0] level;
	logic [3:0] press;

	modport deb (input raw, output level, press);
	modport ctl (output raw, input level, press);
endinterface : bmrc_if

/* core/bmrc_debounce.sv */
// Synchroniser and debouncer for the button and handshake inputs
`include "bmrc_regs.svh"
module bmrc_debounce import bmrc_pkg::*; #(
	parameter int unsigned DEB_CYC = int'(`BMRC_DEB_CYC)
) (
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_clk_en,
	// Inputs in, clean levels and press pulses out
	bmrc_if.deb io
);

	localparam int CW = $clog2(DEB_CYC + 1);

	typedef struct packed {
		bmrc_lanes_t s1;
		bmrc_lanes_t s2;
		bmrc_lanes_t lvl;
		bmrc_lanes_t prs;
		logic [3:0][CW-1:0] cnt;
	} bmrc_deb_t;

	bmrc_deb_t r;
	bmrc_deb_t n;

	// ==========================================================
	// Filter: a lane changes only after staying put for the full count
	always_comb begin
		n = r;
		n.s1 = io.raw;
		n.s2 = r.s1;
		n.prs = '0;
		for (int i = 0; i < 4; i++) begin
			if (r.s2[i] != r.lvl[i]) begin
				if (r.cnt[i] == CW'(DEB_CYC - 1)) begin
					n.lvl[i] = r.s2[i];
					n.cnt[i] = '0;
					n.prs[i] = r.s2[i];
				end else begin
					n.cnt[i] = r.cnt[i] + CW'(1);
				end
			end else begin
				n.cnt[i] = '0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= '0;
		end else if (i_clk_en) begin
			r <= n;
		end
	end

	assign io.level = r.lvl;
	assign io.press = r.prs;

endmodule : bmrc_debounce

/* core/bmrc_top.sv */
// Boot mode reset controller: reset, NMI and mode-select sequencing
// ==========================================================
// Notes on behaviour
// - Power-up starts a timed target reset
// - Reset ends in user mode
// - One debounced NMI pulse per press in user run
// - Boot press starts a full timed reset
// - Boot mode driven throughout boot reset
// - Boot press during user reset only restarts timer
// - Boot mode value fixed at three
// - Mode lines released by output enable
// - Every reset lasts over 500 ms
// - New activation during reset restarts timer
// - Held reset, boot or host input holds reset, then 500 ms
// - Four states, two user, two boot
// - First state holds reset until expiry
// - Second state waits for control event
// - Host low request toggles boot and user
// - Ready line high in boot mode
// - Mode applied while reset held
// - Four mode lines carry mode bits
`include "bmrc_regs.svh"
module bmrc_top import bmrc_pkg::*; #(
	parameter int unsigned RST_CYC = int'(`BMRC_RST_CYC),
	parameter int unsigned DEB_CYC = int'(`BMRC_DEB_CYC),
	parameter int unsigned NMI_CYC = int'(`BMRC_NMI_CYC)
) (
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_clk_en,
	// Buttons and host handshake, all active low
	input wire logic i_rst_btn_n,
	input wire logic i_boot_btn_n,
	input wire logic i_nmi_btn_n,
	input wire logic i_cts_n,
	// Host handshake feedback
	output logic o_rts,
	// Target reset and NMI, active low
	output logic o_tgt_rst_n,
	output logic o_tgt_nmi_n,
	// Target mode-select lines and their common enable
	output logic o_mode_select_bit0,
	output logic o_mode_select_bit1,
	output logic o_mode_select_bit2,
	output logic o_mode_select_bit3,
	output logic o_mode_select_oe,
	// Avalon-MM slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest
);

	localparam int TW = $clog2(RST_CYC + 1);
	localparam int NW = $clog2(NMI_CYC + 1);

	typedef struct packed {
		bmrc_state_t st;
		logic [TW-1:0] tmr;
		logic rst_n;
		logic [3:0] md;
		logic md_oe;
		logic rts;
		logic nmi_n;
		logic [NW-1:0] nmi_tmr;
		logic [7:0] nmi_cnt;
		logic nmi_en;
		logic sw_boot;
		logic sw_rst;
		logic wreq;
		logic [31:0] rdata;
	} bmrc_top_t;

	localparam bmrc_top_t RST_VAL = '{
		st: BMRC_ST_USR_RST,
		tmr: TW'(RST_CYC),
		rst_n: 1'b0,
		md: 4'h0,
		md_oe: 1'b0,
		rts: 1'b0,
		nmi_n: 1'b1,
		nmi_tmr: '0,
		nmi_cnt: 8'h00,
		nmi_en: `BMRC_NMIEN_RST,
		sw_boot: 1'b0,
		sw_rst: 1'b0,
		wreq: 1'b1,
		rdata: 32'h0000_0000
	};

	bmrc_top_t r;
	bmrc_top_t n;
	bmrc_if u_if();

	logic rst_ev;
	logic boot_ev;
	logic cts_ev;
	logic hold;

	// ==========================================================
	// Address decode shared by reads and writes
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// ==========================================================
	// Input conditioning
	assign u_if.raw = {~i_cts_n, ~i_nmi_btn_n, ~i_boot_btn_n, ~i_rst_btn_n};

	bmrc_debounce #(
		.DEB_CYC(DEB_CYC)
	) u_deb (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_clk_en(i_clk_en),
		.io(u_if.deb)
	);

	// ==========================================================
	// Control events; software requests act like button presses
	always_comb begin
		rst_ev = u_if.press[`BMRC_IN_RST] | r.sw_rst;
		boot_ev = u_if.press[`BMRC_IN_BOOT] | r.sw_boot;
		cts_ev = u_if.press[`BMRC_IN_CTS];
		hold = u_if.level[`BMRC_IN_RST] | u_if.level[`BMRC_IN_BOOT]
			| u_if.level[`BMRC_IN_CTS];
	end

	// ==========================================================
	// Next state
	always_comb begin
		n = r;
		n.sw_boot = 1'b0;
		n.sw_rst = 1'b0;

		// Sequencer
		case (r.st)
			BMRC_ST_USR_RST: begin
				// Boot and host requests only stretch a user reset
				if (hold || rst_ev || boot_ev || cts_ev) begin
					n.tmr = TW'(RST_CYC);
				end else if (r.tmr == '0) begin
					n.st = BMRC_ST_USR_RUN;
				end else begin
					n.tmr = r.tmr - TW'(1);
				end
			end
			BMRC_ST_USR_RUN: begin
				if (rst_ev) begin
					n.st = BMRC_ST_USR_RST;
					n.tmr = TW'(RST_CYC);
				end else if (boot_ev || cts_ev) begin
					n.st = BMRC_ST_BOOT_RST;
					n.tmr = TW'(RST_CYC);
				end
			end
			BMRC_ST_BOOT_RST: begin
				if (rst_ev) begin
					n.st = BMRC_ST_USR_RST;
					n.tmr = TW'(RST_CYC);
				end else if (hold || boot_ev || cts_ev) begin
					n.tmr = TW'(RST_CYC);
				end else if (r.tmr == '0) begin
					n.st = BMRC_ST_BOOT_RUN;
				end else begin
					n.tmr = r.tmr - TW'(1);
				end
			end
			BMRC_ST_BOOT_RUN: begin
				if (rst_ev || cts_ev) begin
					n.st = BMRC_ST_USR_RST;
					n.tmr = TW'(RST_CYC);
				end else if (boot_ev) begin
					n.st = BMRC_ST_BOOT_RST;
					n.tmr = TW'(RST_CYC);
				end
			end
			default: begin
				n.st = BMRC_ST_USR_RST;
				n.tmr = TW'(RST_CYC);
			end
		endcase

		// Pin levels follow the next state so they change with it
		n.rst_n = (n.st == BMRC_ST_USR_RUN) || (n.st == BMRC_ST_BOOT_RUN);
		n.md_oe = (n.st == BMRC_ST_BOOT_RST);
		n.md = n.md_oe ? `BMRC_BOOT_MODE : 4'h0;
		n.rts = (n.st == BMRC_ST_BOOT_RST) || (n.st == BMRC_ST_BOOT_RUN);

		// NMI pulse, only while running in user mode
		if (n.st != BMRC_ST_USR_RUN || r.st != BMRC_ST_USR_RUN) begin
			n.nmi_tmr = '0;
		end else if (u_if.press[`BMRC_IN_NMI] && r.nmi_en && r.nmi_tmr == '0) begin
			n.nmi_tmr = NW'(NMI_CYC);
			n.nmi_cnt = r.nmi_cnt + 8'h01;
		end else if (r.nmi_tmr != '0) begin
			n.nmi_tmr = r.nmi_tmr - NW'(1);
		end
		n.nmi_n = (n.nmi_tmr == '0);

		// Bus slave: answer one cycle after the request is seen
		if ((i_avs_read || i_avs_write) && r.wreq) begin
			n.wreq = 1'b0;
			n.rdata = 32'h0000_0000;
			if (i_avs_read) begin
				if (hit(i_avs_address, `BMRC_OFS_CTRL)) begin
					n.rdata[`BMRC_CTRL_NMIEN] = r.nmi_en;
				end else if (hit(i_avs_address, `BMRC_OFS_STAT)) begin
					n.rdata[6:0] = {r.md_oe, ~r.rst_n, r.rts, r.st};
				end else if (hit(i_avs_address, `BMRC_OFS_NMIC)) begin
					n.rdata[7:0] = r.nmi_cnt;
				end else if (hit(i_avs_address, `BMRC_OFS_TMR)) begin
					n.rdata = 32'(r.tmr);
				end
			end
		end else begin
			n.wreq = 1'b1;
		end

		// Writes land at the edge where waitrequest is seen low
		if (i_avs_write && !r.wreq && i_avs_byteenable[0]) begin
			if (hit(i_avs_address, `BMRC_OFS_CTRL)) begin
				n.sw_boot = i_avs_writedata[`BMRC_CTRL_BOOT];
				n.sw_rst = i_avs_writedata[`BMRC_CTRL_RST];
				n.nmi_en = i_avs_writedata[`BMRC_CTRL_NMIEN];
			end
		end
	end

	// ==========================================================
	// State register; power-up is the asynchronous reset
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= RST_VAL;
		end else if (i_clk_en) begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs
	assign o_rts = r.rts;
	assign o_tgt_rst_n = r.rst_n;
	assign o_tgt_nmi_n = r.nmi_n;
	assign o_mode_select_bit0 = r.md[0];
	assign o_mode_select_bit1 = r.md[1];
	assign o_mode_select_bit2 = r.md[2];
	assign o_mode_select_bit3 = r.md[3];
	assign o_mode_select_oe = r.md_oe;
	assign o_avs_readdata = r.rdata;
	assign o_avs_waitrequest = r.wreq;

endmodule : bmrc_top

/* test/bmrc_target.sv */
// Target model: latches mode lines at reset release, counts NMI pulses
module bmrc_target #(
	parameter logic [3:0] JMP = 4'hA
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_nmi_n,
	input wire logic [3:0] i_md,
	input wire logic i_oe,
	output logic [3:0] o_mode,
	output int o_nmis
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// Jumpers pull the lines whenever the controller lets go
	wire logic [3:0] pins = i_oe ? i_md : JMP;
	logic nmi_q;
	// Sampled on the clock so the last value before release wins
	// A target reset clears the pulse count, as it would in real code
	always @(posedge i_sys_clk) begin
		nmi_q <= i_nmi_n;
		if (!i_rst_n) begin
			o_mode <= pins;
			o_nmis <= 0;
		end else if (nmi_q === 1'b1 && i_nmi_n === 1'b0) begin
			o_nmis <= o_nmis + 1;
		end
	end
endmodule : bmrc_target

/* test/bmrc_top_asserts.sv */
// Port checker for the boot mode reset controller
module bmrc_top_asserts #(
	parameter int unsigned RST_CYC = 40
) (
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic o_rts,
	input wire logic o_tgt_rst_n,
	input wire logic o_tgt_nmi_n,
	input wire logic o_mode_select_bit0,
	input wire logic o_mode_select_bit1,
	input wire logic o_mode_select_bit2,
	input wire logic o_mode_select_bit3,
	input wire logic o_mode_select_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// Low-time counter: resets are too long to unroll
	logic [31:0] low_r;
	wire logic [3:0] md = {o_mode_select_bit3, o_mode_select_bit2, o_mode_select_bit1,
		o_mode_select_bit0};
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			low_r <= '0;
		end else if (o_tgt_rst_n) begin
			low_r <= '0;
		end else begin
			low_r <= low_r + 32'h1;
		end
	end
	property p_oe_rts; o_mode_select_oe |-> o_rts; endproperty
	a_oe_rts: assert property (p_oe_rts) else $error("rts low while driving mode");
	property p_mode_val; o_mode_select_oe |-> md == 4'h3; endproperty
	a_mode_val: assert property (p_mode_val) else $error("boot mode value wrong");
	property p_oe_rst; o_mode_select_oe |-> !o_tgt_rst_n; endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("mode driven outside reset");
	property p_idle_md; !o_mode_select_oe |-> md == 4'h0; endproperty
	a_idle_md: assert property (p_idle_md) else $error("mode lines busy while off");
	property p_rst_len; $rose(o_tgt_rst_n) |-> low_r >= RST_CYC; endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset too short");
	property p_rts_rst; $changed(o_rts) |-> !o_tgt_rst_n; endproperty
	a_rts_rst: assert property (p_rts_rst) else $error("mode changed out of reset");
	property p_nmi_len; $fell(o_tgt_nmi_n) |-> (!o_tgt_nmi_n)[*3] ##1 o_tgt_nmi_n; endproperty
	a_nmi_len: assert property (p_nmi_len) else $error("nmi pulse width wrong");
	property p_nmi_usr; $fell(o_tgt_nmi_n) |-> o_tgt_rst_n && !o_rts; endproperty
	a_nmi_usr: assert property (p_nmi_usr) else $error("nmi outside user run");
endmodule : bmrc_top_asserts

bind bmrc_top bmrc_top_asserts #(.RST_CYC(RST_CYC)) u_chk (.i_sys_clk, .i_nrst, .o_rts,
	.o_tgt_rst_n, .o_tgt_nmi_n, .o_mode_select_bit0, .o_mode_select_bit1,
	.o_mode_select_bit2, .o_mode_select_bit3, .o_mode_select_oe);

/* test/tb_boot_mode_reset_controller.sv */
// Testbench for the boot mode reset controller
module tb_boot_mode_reset_controller;
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// Short counts keep the run small
	localparam int RST = 40;
	logic i_sys_clk = 0, i_nrst = 0, i_avs_read = 0, i_avs_write = 0, en = 1;
	logic [3:0] btn_n = 4'hF, i_avs_address = 4'h0, tmode;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
	logic o_rts, o_tgt_rst_n, o_tgt_nmi_n, o_mode_select_oe, o_avs_waitrequest;
	logic o_mode_select_bit0, o_mode_select_bit1, o_mode_select_bit2, o_mode_select_bit3;
	int n_mismatch = 0, comparisons = 0, cyc = 0, n, nmis;
	bmrc_top #(.RST_CYC(RST), .DEB_CYC(4), .NMI_CYC(3)) uut (.i_sys_clk, .i_nrst,
		.i_clk_en(en), .i_rst_btn_n(btn_n[0]), .i_boot_btn_n(btn_n[1]),
		.i_nmi_btn_n(btn_n[2]), .i_cts_n(btn_n[3]), .o_rts, .o_tgt_rst_n, .o_tgt_nmi_n,
		.o_mode_select_bit0, .o_mode_select_bit1, .o_mode_select_bit2, .o_mode_select_bit3,
		.o_mode_select_oe, .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_byteenable(4'hF), .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest);
	bmrc_target tgt (.i_sys_clk, .i_rst_n(o_tgt_rst_n), .i_nmi_n(o_tgt_nmi_n),
		.i_md({o_mode_select_bit3, o_mode_select_bit2, o_mode_select_bit1,
		o_mode_select_bit0}), .i_oe(o_mode_select_oe), .o_mode(tmode), .o_nmis(nmis));
	initial forever #50 i_sys_clk = ~i_sys_clk;
	task automatic tally_and_finish;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// Hang guard well above the longest sequence
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= w;
		i_avs_read <= !w;
		@(posedge i_sys_clk iff !o_avs_waitrequest);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		@(posedge i_sys_clk);
	endtask : bus
	task automatic press(input int b, input int len);
		btn_n[b] <= 1'b0;
		repeat (len) @(posedge i_sys_clk);
		btn_n[b] <= 1'b1;
		repeat (10) @(posedge i_sys_clk);
	endtask : press
	task automatic rel();
		for (n = 0; n < 300 && !o_tgt_rst_n; n++) @(posedge i_sys_clk);
		repeat (2) @(posedge i_sys_clk);
	endtask : rel
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_nrst <= 1'b1;
		rel();
		chk(n >= RST, 1);
		bus(0, 4'h4, 0);
		chk(q, 32'h2);
		bus(0, 4'h2, 0);
		chk(q, 32'h0);
		repeat (2) press(2, 10);
		chk(nmis, 2);
		bus(0, 4'h8, 0);
		chk(q, 32'h2);
		press(1, 60);
		chk(o_tgt_rst_n, 0);
		rel();
		// Press already spent 10 edges after the button let go
		chk(n + 10 >= RST, 1);
		chk(tmode, 4'h3);
		bus(0, 4'h4, 0);
		chk(q, 32'h18);
		press(3, 10);
		rel();
		chk({o_rts, tmode}, 5'h0A);
		press(3, 10);
		rel();
		chk({o_rts, tmode}, 5'h13);
		press(0, 10);
		press(1, 10);
		rel();
		chk({o_rts, tmode}, 5'h0A);
		bus(1, 4'h0, 32'h5);
		// A frozen clock enable must stop the reset timer
		en <= 1'b0;
		repeat (60) @(posedge i_sys_clk);
		chk(o_tgt_rst_n, 0);
		en <= 1'b1;
		rel();
		chk({o_rts, tmode}, 5'h13);
		tally_and_finish;
	end
endmodule : tb_boot_mode_reset_controller
